// ==== hw/usbm_pkg.sv ====
// Package: register map, field positions, mode codes and response codes
package usbm_pkg;

    // ------------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam int         USBM_NUM_EP       = 5;
    localparam logic [7:0] USBM_IDX_CNT0     = 8'h11;
    localparam logic [7:0] USBM_IDX_MODE0    = 8'h12;
    localparam logic [7:0] USBM_IDX_CNT1     = 8'h13;
    localparam logic [7:0] USBM_IDX_MODE1    = 8'h14;
    localparam logic [7:0] USBM_IDX_CNT2     = 8'h15;
    localparam logic [7:0] USBM_IDX_MODE2    = 8'h16;
    localparam logic [7:0] USBM_IDX_CNT3     = 8'h41;
    localparam logic [7:0] USBM_IDX_MODE3    = 8'h42;
    localparam logic [7:0] USBM_IDX_CNT4     = 8'h43;
    localparam logic [7:0] USBM_IDX_MODE4    = 8'h44;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int USBM_CNT_TOG_BIT   = 7;    // Packet toggle
    localparam int USBM_CNT_DVAL_BIT  = 6;    // Data valid
    localparam int USBM_MODE_SETUP_BIT = 7;   // EP0 SETUP seen
    localparam int USBM_MODE_STALL_BIT = 7;   // Non-control stall
    localparam int USBM_MODE_IN_BIT   = 6;    // EP0 IN seen
    localparam int USBM_MODE_OUT_BIT  = 5;    // EP0 OUT seen
    localparam int USBM_MODE_ACK_BIT  = 4;    // Ended with ACK

    // ------------------------------------------------------------------
    // Reset values and limits
    // ------------------------------------------------------------------
    localparam logic [7:0] USBM_MODE_RST   = 8'h00;
    localparam logic [7:0] USBM_CNT_RST    = 8'h00;
    localparam logic [5:0] USBM_RX_CRC_LEN = 6'h02;  // Zero-length data + CRC
    localparam int         USBM_MAX_IN     = 32;

    // ------------------------------------------------------------------
    // Mode encodings
    // ------------------------------------------------------------------
    localparam logic [3:0] M_DISABLE   = 4'h0;
    localparam logic [3:0] M_NAK_IO    = 4'h1;
    localparam logic [3:0] M_STAT_OUT  = 4'h2;
    localparam logic [3:0] M_STALL_IO  = 4'h3;
    localparam logic [3:0] M_IGN_IO    = 4'h4;
    localparam logic [3:0] M_ISO_OUT   = 4'h5;
    localparam logic [3:0] M_STAT_IN   = 4'h6;
    localparam logic [3:0] M_ISO_IN    = 4'h7;
    localparam logic [3:0] M_NAK_OUT   = 4'h8;
    localparam logic [3:0] M_ACK_OUT   = 4'h9;
    localparam logic [3:0] M_NAKO_STI  = 4'hA;
    localparam logic [3:0] M_ACKO_STI  = 4'hB;
    localparam logic [3:0] M_NAK_IN    = 4'hC;
    localparam logic [3:0] M_ACK_IN    = 4'hD;
    localparam logic [3:0] M_NAKI_STO  = 4'hE;
    localparam logic [3:0] M_ACKI_STO  = 4'hF;

    // Token kinds from the packet layer
    typedef enum logic [1:0] {
        PID_SETUP = 2'b00,
        PID_IN    = 2'b01,
        PID_OUT   = 2'b10,
        PID_NONE  = 2'b11
    } usbm_pid_t;

    // Answers handed back to the packet layer
    typedef enum logic [2:0] {
        RSP_IGNORE = 3'b000,
        RSP_ACK    = 3'b001,
        RSP_NAK    = 3'b010,
        RSP_STALL  = 3'b011,
        RSP_TX0    = 3'b100,
        RSP_TXCNT  = 3'b101,
        RSP_RECV   = 3'b110,
        RSP_CHECK  = 3'b111
    } usbm_rsp_t;

endpackage

// ==== hw/usbm_ep_ctrl.sv ====
// Endpoint mode and byte-count engine with classic Wishbone register slave
`timescale 1ns/100ps
module usbm_ep_ctrl
    import usbm_pkg::*;
#(
    parameter int NUM_EP = USBM_NUM_EP
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone classic slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [31:0] adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // Token phase from the serial interface engine
    input  wire logic        tok_valid_i,
    input  wire logic [2:0]  tok_ep_i,
    input  wire logic [1:0]  tok_pid_i,
    input  wire logic        setup_start_i,
    // Transaction end from the serial interface engine
    input  wire logic        done_i,
    input  wire logic [2:0]  done_ep_i,
    input  wire logic [1:0]  done_pid_i,
    input  wire logic [5:0]  rx_cnt_i,
    input  wire logic        rx_crc_ok_i,
    input  wire logic        rx_size_ok_i,
    input  wire logic        rx_tog_i,
    input  wire logic        host_ack_i,
    // Answers to the serial interface engine
    output logic             rsp_valid_o,
    output logic      [2:0]  rsp_code_o,
    output logic      [5:0]  tx_count_o,
    output logic             tx_toggle_o,
    output logic      [4:0]  ep_int_o
);

    // ------------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------------
    if (NUM_EP != USBM_NUM_EP) begin : g_bad_ep
        $error("usbm_ep_ctrl: register map serves exactly five endpoints");
    end

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [4:0][7:0] mode;       // Mode registers
        logic [4:0][7:0] cnt;        // Count registers
        logic            mode_lock;  // EP0 mode bits 6:0 write lock
        logic            cnt_lock;   // EP0 count write lock
        logic            setup_hold; // SETUP flag being forced
        logic            setup_lock; // SETUP flag kept until read
        logic            ack;        // Wishbone acknowledge
        logic [7:0]      rdat;       // Read data
        logic            rsp_vld;    // Answer strobe
        logic [2:0]      rsp;        // Answer code
        logic [5:0]      txc;        // Count to send
        logic            txt;        // Toggle to send
        logic [4:0]      intp;       // Endpoint interrupt pulses
    } usbm_state_t;

    usbm_state_t st_ff;              // Registered state
    usbm_state_t nxt_st;             // Next state

    // Address decode: one hit line per count and per mode register
    logic [4:0] cnt_hit;             // Count register selected
    logic [4:0] mode_hit;            // Mode register selected
    logic       adr_hi_zero;         // Address bits 31:10 and 1:0 clear
    logic       take;                // Request accepted this cycle
    logic       wr_take;             // Write accepted
    logic       rd_take;             // Read accepted

    localparam logic [7:0] CNT_IDX  [5] = '{USBM_IDX_CNT0, USBM_IDX_CNT1,
        USBM_IDX_CNT2, USBM_IDX_CNT3, USBM_IDX_CNT4};
    localparam logic [7:0] MODE_IDX [5] = '{USBM_IDX_MODE0, USBM_IDX_MODE1,
        USBM_IDX_MODE2, USBM_IDX_MODE3, USBM_IDX_MODE4};

    assign adr_hi_zero = (adr_i[31:10] == 22'h0) && (adr_i[1:0] == 2'h0);
    assign take        = cyc_i && stb_i && !st_ff.ack;
    assign wr_take     = take && we_i && sel_i[0];
    assign rd_take     = take && !we_i;

    for (genvar e = 0; e < 5; e++) begin : g_dec
        assign cnt_hit[e]  = adr_hi_zero && (adr_i[9:2] == CNT_IDX[e]);
        assign mode_hit[e] = adr_hi_zero && (adr_i[9:2] == MODE_IDX[e]);
    end

    // ------------------------------------------------------------------
    // Answer of a mode to a token
    // ------------------------------------------------------------------
    function automatic usbm_rsp_t mode_rsp(input logic [3:0] m, input logic stall,
                                           input logic [1:0] pid);
        usbm_rsp_t r;
        r = RSP_IGNORE;
        case (pid)
            PID_SETUP: begin
                // Control modes accept SETUP, the rest ignore it
                case (m)
                    M_NAK_IO, M_STAT_OUT, M_STALL_IO, M_IGN_IO, M_STAT_IN,
                    M_NAKO_STI, M_ACKO_STI, M_NAKI_STO, M_ACKI_STO: r = RSP_RECV;
                    default: r = RSP_IGNORE;
                endcase
            end
            PID_IN: begin
                case (m)
                    M_NAK_IO, M_NAK_IN, M_NAKI_STO: r = RSP_NAK;
                    M_STAT_OUT, M_STALL_IO:         r = RSP_STALL;
                    M_STAT_IN, M_NAKO_STI, M_ACKO_STI: r = RSP_TX0;
                    M_ISO_IN, M_ACKI_STO:           r = RSP_TXCNT;
                    M_ACK_IN: r = stall ? RSP_STALL : RSP_TXCNT;
                    default:                        r = RSP_IGNORE;
                endcase
            end
            PID_OUT: begin
                case (m)
                    M_NAK_IO, M_NAK_OUT, M_NAKO_STI: r = RSP_NAK;
                    M_STAT_OUT, M_NAKI_STO, M_ACKI_STO: r = RSP_CHECK;
                    M_STALL_IO, M_STAT_IN:          r = RSP_STALL;
                    M_ISO_OUT, M_ACKO_STI:          r = RSP_ACK;
                    M_ACK_OUT: r = stall ? RSP_STALL : RSP_ACK;
                    default:                        r = RSP_IGNORE;
                endcase
            end
            default: r = RSP_IGNORE;
        endcase
        return r;
    endfunction

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        logic [7:0]  md;             // Mode of the finishing endpoint
        logic [7:0]  md_new;         // Its updated mode
        usbm_rsp_t   r;              // Base answer at transaction end
        logic        dvalid;         // Received packet is good
        logic        ctl;            // Endpoint 0 is the control endpoint
        logic        cnt_upd;        // Count refreshed
        logic        irq;            // Raise endpoint flag
        md      = 8'h00;
        md_new  = 8'h00;
        r       = RSP_IGNORE;
        dvalid  = rx_crc_ok_i && rx_size_ok_i;
        ctl     = (done_ep_i == 3'h0);
        cnt_upd = 1'b0;
        irq     = 1'b0;
        nxt_st  = st_ff;
        nxt_st.ack     = take;
        nxt_st.rsp_vld = 1'b0;
        nxt_st.intp    = 5'h0;

        // Register read: the value shows the block's live state
        if (rd_take) begin
            nxt_st.rdat = 8'h00;     // Unmapped addresses read zero
            for (int e = 0; e < 5; e++) begin
                if (cnt_hit[e]) nxt_st.rdat = st_ff.cnt[e];
                if (mode_hit[e]) nxt_st.rdat = st_ff.mode[e];
            end
            if (cnt_hit[0]) nxt_st.cnt_lock = 1'b0;
            if (mode_hit[0]) begin
                nxt_st.mode_lock = 1'b0;
                if (!st_ff.setup_hold) nxt_st.setup_lock = 1'b0;
            end
        end

        // Register write; locked EP0 fields keep their value
        if (wr_take) begin
            for (int e = 1; e < 5; e++) begin
                if (cnt_hit[e]) nxt_st.cnt[e] = dat_i[7:0];
                // Reserved bits 6:5 of non-control modes store zero
                if (mode_hit[e]) nxt_st.mode[e] = dat_i[7:0] & 8'h9F;
            end
            if (cnt_hit[0] && !st_ff.cnt_lock) nxt_st.cnt[0] = dat_i[7:0];
            if (mode_hit[0]) begin
                if (!st_ff.mode_lock) nxt_st.mode[0][6:0] = dat_i[6:0];
                if (!st_ff.setup_hold && !st_ff.setup_lock) begin
                    nxt_st.mode[0][USBM_MODE_SETUP_BIT] = dat_i[7];
                end
            end
        end

        // Token phase: decide the answer; the packet layer waits one cycle
        if (tok_valid_i && (tok_ep_i < 3'h5)) begin
            nxt_st.rsp_vld = 1'b1;
            nxt_st.rsp = mode_rsp(st_ff.mode[tok_ep_i][3:0],
                st_ff.mode[tok_ep_i][USBM_MODE_STALL_BIT] && (tok_ep_i != 3'h0),
                tok_pid_i);
            nxt_st.txc = st_ff.cnt[tok_ep_i][5:0];
            nxt_st.txt = st_ff.cnt[tok_ep_i][USBM_CNT_TOG_BIT];
        end

        // SETUP time point: force the flag and hold it against firmware
        if (setup_start_i) begin
            nxt_st.mode[0][USBM_MODE_SETUP_BIT] = 1'b1;
            nxt_st.setup_hold = 1'b1;
            nxt_st.setup_lock = 1'b1;
        end

        // Update point: hardware wins over a same-cycle firmware access
        if (done_i && (done_ep_i < 3'h5)) begin
            md     = st_ff.mode[done_ep_i];
            md_new = md;
            r      = mode_rsp(md[3:0], md[USBM_MODE_STALL_BIT] && !ctl, done_pid_i);
            case (done_pid_i)
                PID_SETUP: begin
                    if (r == RSP_RECV) begin
                        cnt_upd = 1'b1;
                        irq     = 1'b1;
                        if (dvalid) begin
                            md_new[3:0] = M_NAK_IO;
                            md_new[USBM_MODE_ACK_BIT] = 1'b1;
                            nxt_st.rsp_vld = 1'b1;
                            nxt_st.rsp     = RSP_ACK;
                        end
                    end
                    // Any EP0 SETUP end, ACKed or not, ends the forced interval; the lock stays
                    if (ctl) nxt_st.setup_hold = 1'b0;
                end
                PID_OUT: begin
                    if (r != RSP_IGNORE) begin
                        irq = 1'b1;
                        if (ctl) md_new[USBM_MODE_OUT_BIT] = 1'b1;
                    end
                    nxt_st.rsp_vld = (r != RSP_IGNORE);
                    nxt_st.rsp     = r;
                    if (r == RSP_ACK) begin
                        cnt_upd = 1'b1;
                        if (!dvalid) begin
                            nxt_st.rsp = RSP_IGNORE;
                        end else if (md[3:0] == M_ISO_OUT) begin
                            nxt_st.rsp_vld = 1'b0;                          // No handshake
                        end else begin
                            md_new[USBM_MODE_ACK_BIT] = 1'b1;
                            if (md[3] && md[0]) md_new[0] = 1'b0;
                        end
                    end else if (r == RSP_CHECK) begin
                        // Status stage: zero-length DATA1 or stall
                        if (dvalid && (rx_cnt_i == USBM_RX_CRC_LEN) && rx_tog_i) begin
                            nxt_st.rsp = RSP_ACK;
                            md_new[USBM_MODE_ACK_BIT] = 1'b1;
                            cnt_upd = 1'b1;
                        end else begin
                            nxt_st.rsp = RSP_STALL;
                        end
                    end
                end
                PID_IN: begin
                    if (r != RSP_IGNORE) begin
                        irq = 1'b1;
                        if (ctl) md_new[USBM_MODE_IN_BIT] = 1'b1;
                    end
                    if (((r == RSP_TX0) || (r == RSP_TXCNT)) && host_ack_i) begin
                        md_new[USBM_MODE_ACK_BIT] = 1'b1;
                        if (md[3] && md[0]) md_new[0] = 1'b0;
                    end
                end
                default: ;
            endcase

            // SETUP bit of EP0 is owned by the SETUP time point
            if (ctl) md_new[USBM_MODE_SETUP_BIT] = nxt_st.mode[0][USBM_MODE_SETUP_BIT];
            nxt_st.mode[done_ep_i] = md_new;
            if (cnt_upd) begin
                nxt_st.cnt[done_ep_i][5:0] = rx_cnt_i;
                nxt_st.cnt[done_ep_i][USBM_CNT_DVAL_BIT] = dvalid;
                nxt_st.cnt[done_ep_i][USBM_CNT_TOG_BIT] = rx_tog_i;
            end
            // Lock only EP0, and only what this update touched
            if (ctl && (md_new[6:0] != md[6:0])) nxt_st.mode_lock = 1'b1;
            if (ctl && cnt_upd) nxt_st.cnt_lock = 1'b1;
            nxt_st.intp[done_ep_i] = irq;
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_ff <= '0;             // All modes disabled, counts clear
            for (int e = 0; e < 5; e++) begin
                st_ff.mode[e] <= USBM_MODE_RST;
                st_ff.cnt[e]  <= USBM_CNT_RST;
            end
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------------
    // Outputs, all from flip-flops
    // ------------------------------------------------------------------
    assign dat_o       = {24'h000000, st_ff.rdat};
    assign ack_o       = st_ff.ack;
    assign rsp_valid_o = st_ff.rsp_vld;
    assign rsp_code_o  = st_ff.rsp;
    assign tx_count_o  = st_ff.txc;
    assign tx_toggle_o = st_ff.txt;
    assign ep_int_o    = st_ff.intp;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_ep0_setup_done;
        done_i && (done_ep_i == 3'h0) && (done_pid_i == PID_SETUP)
            && (mode_rsp(st_ff.mode[0][3:0], 1'b0, PID_SETUP) == RSP_RECV);
    endsequence

    sequence s_ep1_in_ack;
        done_i && (done_ep_i == 3'h1) && (done_pid_i == PID_IN) && host_ack_i
            && (st_ff.mode[1][3:0] == M_ACK_IN) && !st_ff.mode[1][7];
    endsequence

    AST_RESET_DISABLED: assert property ($past(rst_i) |-> (st_ff.mode == '0))
        else $error("mode not disabled after reset");
    AST_IGNORE_DISABLED: assert property (tok_valid_i && (tok_ep_i < 3'h5)
        && (st_ff.mode[tok_ep_i][3:0] == M_DISABLE) |=> rsp_code_o == RSP_IGNORE)
        else $error("disabled endpoint answered traffic");
    AST_SETUP_FORCE: assert property (setup_start_i |=> st_ff.mode[0][7]
        && st_ff.setup_hold)
        else $error("SETUP flag not forced");
    AST_SETUP_MODE: assert property (s_ep0_setup_done ##0 rx_crc_ok_i && rx_size_ok_i
        |=> (st_ff.mode[0][3:0] == M_NAK_IO) && rsp_valid_o && (rsp_code_o == RSP_ACK))
        else $error("valid SETUP did not switch to NAK mode");
    AST_SETUP_COUNT: assert property (s_ep0_setup_done |=>
        (st_ff.cnt[0][5:0] == $past(rx_cnt_i)) && (st_ff.cnt[0][7] == $past(rx_tog_i))
        && st_ff.cnt_lock)
        else $error("SETUP count or toggle not stored");
    AST_BAD_CRC: assert property (s_ep0_setup_done ##0 !rx_crc_ok_i
        |=> !st_ff.cnt[0][6] && ep_int_o[0])
        else $error("bad CRC not flagged");
    AST_CNT_LOCKED: assert property (st_ff.cnt_lock && wr_take && cnt_hit[0] && !done_i
        |=> $stable(st_ff.cnt[0]))
        else $error("locked EP0 count was written");
    AST_EP1_OPEN: assert property (wr_take && cnt_hit[1] && !done_i
        |=> st_ff.cnt[1] == $past(dat_i[7:0]))
        else $error("EP1 count write lost");
    AST_UNLOCK_READ: assert property (rd_take && cnt_hit[0] && !done_i
        |=> !st_ff.cnt_lock)
        else $error("read did not release count lock");
    AST_STEP_IN: assert property (s_ep1_in_ack |=> (st_ff.mode[1][3:0] == M_NAK_IN)
        && ep_int_o[1] ##1 !ep_int_o[1])
        else $error("ACKed IN did not step to NAK");
    AST_STALL_IN: assert property (tok_valid_i && (tok_ep_i == 3'h1)
        && (st_ff.mode[1][3:0] == M_ACK_IN) && st_ff.mode[1][7]
        |=> rsp_valid_o && (rsp_code_o == RSP_STALL))
        else $error("stall bit ignored on IN");
    AST_CHECK_OUT: assert property (done_i && (done_ep_i == 3'h0) && (done_pid_i == PID_OUT)
        && (st_ff.mode[0][3:0] == M_STAT_OUT) && (rx_cnt_i != USBM_RX_CRC_LEN)
        |=> rsp_valid_o && (rsp_code_o == RSP_STALL))
        else $error("status OUT with data not stalled");

endmodule // usbm_ep_ctrl

// ==== tb/usbm_host_model.sv ====
// Host-side model: issues tokens and transaction ends to the endpoint engine
`timescale 1ns/100ps
module usbm_host_model
    import usbm_pkg::*;
(
    // Clock
    input  wire logic       clk_i,
    // Token and update strobes with packet status
    output logic            tok_o, setup_o, done_o, crc_o, tog_o, hack_o,
    output logic      [2:0] ep_o, dep_o,
    output logic      [1:0] pid_o, dpid_o,
    output logic      [5:0] cnt_o
);
    initial {tok_o, setup_o, done_o, crc_o, tog_o, hack_o, ep_o, dep_o, pid_o, dpid_o, cnt_o} = '0;
    // Token pulse; fields scrambled after so stale values never pass as valid
    task automatic token(input logic [2:0] e, input logic [1:0] p);
        {tok_o, ep_o, pid_o} <= {1'b1, e, p};
        @(posedge clk_i);
        {tok_o, ep_o, pid_o} <= {1'b0, ~e, ~p};
        repeat (3) @(posedge clk_i);
    endtask
    // Data phase mark for SETUP, then the update pulse with status
    task automatic finish(input logic [2:0] e, input logic [1:0] p,
                          input logic [5:0] c, input logic k, t, h);
        if (p == PID_SETUP) begin
            setup_o <= 1'b1;
            @(posedge clk_i);
            setup_o <= 1'b0;
        end
        {done_o, dep_o, dpid_o, cnt_o, crc_o, tog_o, hack_o} <= {1'b1, e, p, c, k, t, h};
        @(posedge clk_i);
        {done_o, dep_o, dpid_o, cnt_o, crc_o, tog_o, hack_o} <= {1'b0, ~e, ~p, ~c, ~k, ~t, ~h};
        repeat (3) @(posedge clk_i);
    endtask
endmodule // usbm_host_model

// ==== tb/test_usbm_ep_ctrl.sv ====
// Self-checking bench for the endpoint mode and count engine
`timescale 1ns/100ps
module test_usbm_ep_ctrl
    import usbm_pkg::*;
;
    logic        clk_i, rst_i, cyc_i, stb_i, we_i, t;
    logic [31:0] adr_i, dat_i;
    logic [3:0]  sel_i;
    logic [5:0]  c;
    wire  logic [31:0] dat_o;
    wire  logic ack_o, rsp_valid_o, tx_toggle_o, tv, ss, dn, crc, tg, ha;
    wire  logic [2:0] rsp_code_o, te, de;
    wire  logic [1:0] tp, dp;
    wire  logic [5:0] tx_count_o, rc;
    wire  logic [4:0] ep_int_o;
    int          miscompares, cmp_count;
    logic [7:0]  q_rd[$];
    logic [10:0] q_rsp[$];    // Flag, toggle, count, code
    logic [4:0]  q_int[$];
    logic [7:0]  regs[11] = '{8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h41, 8'h42, 8'h43, 8'h44, 8'h20};
    initial begin clk_i = 1'b0; forever #25 clk_i = ~clk_i; end
    usbm_ep_ctrl u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .tok_valid_i(tv), .tok_ep_i(te), .tok_pid_i(tp), .setup_start_i(ss), .done_i(dn),
        .done_ep_i(de), .done_pid_i(dp), .rx_cnt_i(rc), .rx_crc_ok_i(crc), .rx_size_ok_i(crc),
        .rx_tog_i(tg), .host_ack_i(ha), .rsp_valid_o(rsp_valid_o), .rsp_code_o(rsp_code_o),
        .tx_count_o(tx_count_o), .tx_toggle_o(tx_toggle_o), .ep_int_o(ep_int_o));
    usbm_host_model u_host (.clk_i(clk_i), .tok_o(tv), .setup_o(ss), .done_o(dn), .crc_o(crc),
        .tog_o(tg), .hack_o(ha), .ep_o(te), .dep_o(de), .pid_o(tp), .dpid_o(dp), .cnt_o(rc));
    task automatic compare(input logic [31:0] e, g);
        cmp_count++;
        if (e !== g) begin
            miscompares++;
            $display("CHECK FAILED at %0t: exp %0h got %0h", $time, e, g);
        end
    endtask
    task automatic complete_run;
        compare(32'h0, q_rd.size() + q_rsp.size() + q_int.size());
        $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // One classic cycle; waits for ack under a bound
    task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
        int n;
        {cyc_i, stb_i, we_i, sel_i} <= {2'b11, w, 4'hF};
        {adr_i, dat_i} <= {22'h0, idx, 2'h0, 24'h0, d};
        n = 0;
        do begin @(posedge clk_i); n++; end while (ack_o !== 1'b1 && n < 50);
        if (n >= 50) begin miscompares++; complete_run; end
        {cyc_i, stb_i} <= 2'h0;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [7:0] idx, input logic [7:0] e);
        q_rd.push_back(e);
        wb(1'b0, idx, 8'h00);
    endtask
    // Watcher: oldest note against each result as it appears
    always @(posedge clk_i) begin
        if (ack_o === 1'b1 && we_i === 1'b0) compare(q_rd.pop_front(), dat_o);
        if (rsp_valid_o === 1'b1) begin
            compare(q_rsp[0][2:0], rsp_code_o);
            if (q_rsp[0][10]) compare(q_rsp[0][9:3], {tx_toggle_o, tx_count_o});
            void'(q_rsp.pop_front());
        end
        if (|ep_int_o) compare(q_int.pop_front(), ep_int_o);
    end
    initial begin
        {rst_i, cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} = {1'b1, 71'h0};
        void'($urandom(95));
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        foreach (regs[i]) rd(regs[i], 8'h00);
        q_rsp.push_back({8'h00, RSP_IGNORE}); u_host.token(3'h3, PID_IN);
        wb(1'b1, USBM_IDX_MODE4, 8'h8D);
        q_rsp.push_back({8'h00, RSP_STALL}); u_host.token(3'h4, PID_IN);
        $display("Reset and stall test done");
        c = 6'($urandom_range(32)); t = 1'($urandom());
        wb(1'b1, USBM_IDX_CNT1, {t, 1'b0, c});
        wb(1'b1, USBM_IDX_MODE1, 8'h0D);
        q_rsp.push_back({1'b1, t, c, RSP_TXCNT}); u_host.token(3'h1, PID_IN);
        q_int.push_back(5'h02); u_host.finish(3'h1, PID_IN, 6'h00, 1'b1, 1'b0, 1'b1);
        rd(USBM_IDX_MODE1, 8'h1C);
        $display("Bulk IN test done");
        wb(1'b1, USBM_IDX_MODE0, 8'h01);
        c = 6'($urandom_range(10, 2)); t = 1'($urandom());
        q_rsp.push_back({8'h00, RSP_RECV}); u_host.token(3'h0, PID_SETUP);
        q_rsp.push_back({8'h00, RSP_ACK}); q_int.push_back(5'h01);
        u_host.finish(3'h0, PID_SETUP, c, 1'b1, t, 1'b0);
        wb(1'b1, USBM_IDX_CNT0, 8'h05);
        rd(USBM_IDX_CNT0, {t, 1'b1, c});
        rd(USBM_IDX_MODE0, 8'h91);
        wb(1'b1, USBM_IDX_CNT0, 8'h05);
        rd(USBM_IDX_CNT0, 8'h05);
        $display("Setup lock test done");
        wb(1'b1, USBM_IDX_MODE0, 8'h02);
        q_rsp.push_back({8'h00, RSP_CHECK}); u_host.token(3'h0, PID_OUT);
        q_rsp.push_back({8'h00, RSP_ACK}); q_int.push_back(5'h01);
        u_host.finish(3'h0, PID_OUT, USBM_RX_CRC_LEN, 1'b1, 1'b1, 1'b0);
        rd(USBM_IDX_CNT0, 8'hC2);
        q_rsp.push_back({8'h00, RSP_CHECK}); u_host.token(3'h0, PID_OUT);
        q_rsp.push_back({8'h00, RSP_STALL}); q_int.push_back(5'h01);
        u_host.finish(3'h0, PID_OUT, 6'h04, 1'b1, 1'b1, 1'b0);
        rd(USBM_IDX_MODE0, 8'h32);
        $display("Status check test done");
        wb(1'b1, USBM_IDX_MODE2, 8'h09);
        q_rsp.push_back({8'h00, RSP_ACK}); u_host.token(3'h2, PID_OUT);
        q_rsp.push_back({8'h00, RSP_IGNORE}); q_int.push_back(5'h04);
        u_host.finish(3'h2, PID_OUT, c, 1'b0, t, 1'b0);
        rd(USBM_IDX_CNT2, {t, 1'b0, c});
        wb(1'b1, USBM_IDX_CNT2, 8'h3F);
        rd(USBM_IDX_CNT2, 8'h3F);
        $display("Bad packet test done");
        complete_run;
    end
endmodule // test_usbm_ep_ctrl
